// ### design/crxfe_regs.vh
// Constants for the lane front end: line states, packet codes, checks
`ifndef CRXFE_REGS_VH
`define CRXFE_REGS_VH

// Low-power line states {dp, dn}
`define CRXFE_LP_11         2'b11
`define CRXFE_LP_01         2'b01
`define CRXFE_LP_00         2'b00

// Clock lane mode bit position in configuration register
`define CRXFE_CFG_REG       8'h02
`define CRXFE_CFG_CONT_BIT  6

// Lane count codes
`define CRXFE_LANES_1       2'b00
`define CRXFE_LANES_2       2'b01
`define CRXFE_LANES_4       2'b10

// High-speed start byte
`define CRXFE_SYNC_BYTE     8'hb8

// Data types
`define CRXFE_DT_SHORT_MAX  6'h0f
`define CRXFE_DT_FRAME_STA  6'h00
`define CRXFE_DT_FRAME_END  6'h01

// Header protection masks, one per parity bit
`define CRXFE_ECC_M0        24'hf12cb7
`define CRXFE_ECC_M1        24'hf2555b
`define CRXFE_ECC_M2        24'h749a6d
`define CRXFE_ECC_M3        24'hb8e38e
`define CRXFE_ECC_M4        24'hdf03f0
`define CRXFE_ECC_M5        24'heffc00

// Payload checksum
`define CRXFE_CRC_INIT      16'hffff
`define CRXFE_CRC_POLY      16'h8408

`endif

// ### design/crxfe_skid.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module crxfe_skid #(
  parameter WIDTH = 9,
  parameter AW    = 1
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_b_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam DEPTH = 1 << AW;

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      cnt_reg;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // crxfe_skid

// ### design/crxfe_top.v
// Camera serial lane receiver front end: lane states, byte merge, packet parse
`timescale 1ns/100ps
`include "crxfe_regs.vh"
module crxfe_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Configuration
  input  wire        clk_cont_i,
  input  wire [1:0]  lane_cfg_i,
  input  wire        err_clr_i,
  // Lane pins, receive only
  input  wire        hs_clk_i,
  input  wire        lp_cp_i,
  input  wire        lp_cn_i,
  input  wire [3:0]  lp_dp_i,
  input  wire [3:0]  lp_dn_i,
  input  wire [3:0]  hs_d_i,
  // Analog control
  output wire        clk_term_en_o,
  output wire [3:0]  term_en_o,
  // Sync events
  output reg         sync_valid_o,
  output reg  [7:0]  sync_id_o,
  output reg  [15:0] sync_data_o,
  output reg         frame_active_o,
  // Payload stream
  output wire        pay_valid_o,
  input  wire        pay_ready_i,
  output wire [7:0]  pay_data_o,
  output wire        pay_last_o,
  // Status
  output reg         hdr_fix_o,
  output reg         hdr_err_o,
  output reg         crc_err_o,
  output reg         ovr_o,
  output reg         hdr_err_sts_o,
  output reg         crc_err_sts_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_STOP = 2'd1;
  localparam ST_PREP = 2'd2;
  localparam ST_HS   = 2'd3;

  localparam PS_H0 = 3'd0;
  localparam PS_H1 = 3'd1;
  localparam PS_H2 = 3'd2;
  localparam PS_H3 = 3'd3;
  localparam PS_PL = 3'd4;
  localparam PS_C0 = 3'd5;
  localparam PS_C1 = 3'd6;

  // Shared lane state step
  function [1:0] lp_next;
    input [1:0] st;
    input [1:0] lp;
    begin
      if (lp == `CRXFE_LP_11) begin
        lp_next = ST_STOP;
      end else begin
        case (st)
          ST_STOP: lp_next = (lp == `CRXFE_LP_01) ? ST_PREP : ST_IDLE;
          ST_PREP: lp_next = (lp == `CRXFE_LP_00) ? ST_HS :
                             (lp == `CRXFE_LP_01) ? ST_PREP : ST_IDLE;
          ST_HS:   lp_next = ST_HS;
          default: lp_next = ST_IDLE;
        endcase
      end
    end
  endfunction

  // Header protection: returns {bad, fixed, corrected header}
  function [25:0] ecc_fix;
    input [23:0] h;
    input [5:0]  rx;
    reg   [5:0]  syn;
    reg   [23:0] hc;
    reg          hit;
    reg   [23:0] t0, t1, t2, t3, t4, t5;
    integer      i;
    begin
      syn[0] = ^(h & `CRXFE_ECC_M0);
      syn[1] = ^(h & `CRXFE_ECC_M1);
      syn[2] = ^(h & `CRXFE_ECC_M2);
      syn[3] = ^(h & `CRXFE_ECC_M3);
      syn[4] = ^(h & `CRXFE_ECC_M4);
      syn[5] = ^(h & `CRXFE_ECC_M5);
      syn = syn ^ rx;
      hc  = h;
      hit = (syn == 6'h00) || ((syn & (syn - 6'h01)) == 6'h00);
      for (i = 0; i < 24; i = i + 1) begin
        t0 = `CRXFE_ECC_M0 >> i;
        t1 = `CRXFE_ECC_M1 >> i;
        t2 = `CRXFE_ECC_M2 >> i;
        t3 = `CRXFE_ECC_M3 >> i;
        t4 = `CRXFE_ECC_M4 >> i;
        t5 = `CRXFE_ECC_M5 >> i;
        if (syn == {t5[0], t4[0], t3[0], t2[0], t1[0], t0[0]}) begin
          hc[i] = ~h[i];
          hit   = 1'b1;
        end
      end
      ecc_fix = {~hit, syn != 6'h00, hc};
    end
  endfunction

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  b;
    reg   [15:0] r;
    integer      k;
    begin
      r = c;
      for (k = 0; k < 8; k = k + 1) begin
        r = (r[0] ^ b[k]) ? ((r >> 1) ^ `CRXFE_CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [14:0] s1_reg;
  reg [14:0] s2_reg;
  reg        clk_d_reg;
  always @(posedge clk_i) begin
    s1_reg    <= {hs_clk_i, lp_cp_i, lp_cn_i, lp_dp_i, lp_dn_i, hs_d_i};
    s2_reg    <= s1_reg;
    clk_d_reg <= s2_reg[14];
  end
  wire       lk_rise = s2_reg[14] && !clk_d_reg;
  wire [1:0] lp_clk  = s2_reg[13:12];
  wire [3:0] dp_s    = s2_reg[11:8];
  wire [3:0] dn_s    = s2_reg[7:4];
  wire [3:0] hsd_s   = s2_reg[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Clock lane
  reg [1:0] cst_reg;
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cst_reg <= ST_IDLE;
    end else begin
      cst_reg <= lp_next(cst_reg, lp_clk);
    end
  end
  wire clk_hs = clk_cont_i || (cst_reg == ST_HS);
  assign clk_term_en_o = clk_hs;

  // Active lane mask
  wire [3:0] lane_on = (lane_cfg_i == `CRXFE_LANES_4) ? 4'hf :
                       (lane_cfg_i == `CRXFE_LANES_2) ? 4'h3 : 4'h1;
  wire [2:0] n_lanes = (lane_cfg_i == `CRXFE_LANES_4) ? 3'd4 :
                       (lane_cfg_i == `CRXFE_LANES_2) ? 3'd2 : 3'd1;

  ////////////////////////////////////////////////////////////////////////////
  // Data lanes
  wire [31:0] lane_byte;
  wire [3:0]  lane_rdy;
  wire [3:0]  lane_hs;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      reg [1:0] st_reg;
      reg [7:0] sh_reg;
      reg [2:0] bc_reg;
      reg       syn_reg;
      reg [7:0] byte_reg;
      reg       rdy_reg;
      wire [7:0] sh_next = {hsd_s[g], sh_reg[7:1]};
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          st_reg   <= ST_IDLE;
          sh_reg   <= 8'h00;
          bc_reg   <= 3'd0;
          syn_reg  <= 1'b0;
          byte_reg <= 8'h00;
          rdy_reg  <= 1'b0;
        end else begin
          st_reg  <= lane_on[g] ? lp_next(st_reg, {dp_s[g], dn_s[g]}) : ST_IDLE;
          rdy_reg <= 1'b0;
          if (st_reg != ST_HS) begin
            syn_reg <= 1'b0;
            bc_reg  <= 3'd0;
            sh_reg  <= 8'h00;
          end else if (lk_rise && clk_hs) begin
            sh_reg <= sh_next;
            if (!syn_reg) begin
              syn_reg <= (sh_next == `CRXFE_SYNC_BYTE);
            end else begin
              bc_reg <= bc_reg + 3'd1;
              if (bc_reg == 3'd7) begin
                byte_reg <= sh_next;
                rdy_reg  <= 1'b1;
              end
            end
          end
        end
      end
      assign lane_byte[8*g+7:8*g] = byte_reg;
      assign lane_rdy[g]          = rdy_reg;
      assign lane_hs[g]           = (st_reg == ST_HS);
      assign term_en_o[g]         = lane_hs[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Lane merge, lane 0 first
  reg  [31:0] hold_reg;
  reg  [2:0]  pend_reg;
  wire        fifo_rdy;
  wire        step = (pend_reg != 3'd0) && fifo_rdy;
  wire [7:0]  b    = hold_reg[7:0];
  wire        abort = !lane_hs[0];
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      hold_reg <= 32'h0000_0000;
      pend_reg <= 3'd0;
      ovr_o    <= 1'b0;
    end else begin
      ovr_o <= 1'b0;
      if (abort) begin
        pend_reg <= 3'd0;
      end else if (lane_rdy[0]) begin
        if (pend_reg != 3'd0) begin
          ovr_o <= 1'b1;
        end else begin
          hold_reg <= lane_byte;
          pend_reg <= n_lanes;
        end
      end else if (step) begin
        hold_reg <= {8'h00, hold_reg[31:8]};
        pend_reg <= pend_reg - 3'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet parser
  reg  [2:0]  ps_reg;
  reg  [23:0] hdr_reg;
  reg  [15:0] wc_reg;
  reg  [15:0] crc_reg;
  reg  [7:0]  cs_lo_reg;
  wire [25:0] ecc_r = ecc_fix(hdr_reg, b[5:0]);
  wire        push  = step && !abort && (ps_reg == PS_PL);
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ps_reg         <= PS_H0;
      hdr_reg        <= 24'h000000;
      wc_reg         <= 16'h0000;
      crc_reg        <= `CRXFE_CRC_INIT;
      cs_lo_reg      <= 8'h00;
      sync_valid_o   <= 1'b0;
      sync_id_o      <= 8'h00;
      sync_data_o    <= 16'h0000;
      frame_active_o <= 1'b0;
      hdr_fix_o      <= 1'b0;
      hdr_err_o      <= 1'b0;
      crc_err_o      <= 1'b0;
      hdr_err_sts_o  <= 1'b0;
      crc_err_sts_o  <= 1'b0;
    end else begin
      sync_valid_o <= 1'b0;
      hdr_fix_o    <= 1'b0;
      hdr_err_o    <= 1'b0;
      crc_err_o    <= 1'b0;
      if (hdr_err_o || hdr_fix_o) begin
        hdr_err_sts_o <= 1'b1;
      end else if (err_clr_i) begin
        hdr_err_sts_o <= 1'b0;
      end
      if (crc_err_o) begin
        crc_err_sts_o <= 1'b1;
      end else if (err_clr_i) begin
        crc_err_sts_o <= 1'b0;
      end
      if (abort) begin
        ps_reg <= PS_H0;
      end else if (step) begin
        case (ps_reg)
          PS_H0: begin
            hdr_reg[7:0] <= b;
            ps_reg       <= PS_H1;
          end
          PS_H1: begin
            hdr_reg[15:8] <= b;
            ps_reg        <= PS_H2;
          end
          PS_H2: begin
            hdr_reg[23:16] <= b;
            ps_reg         <= PS_H3;
          end
          PS_H3: begin
            ps_reg <= PS_H0;
            if (ecc_r[25]) begin
              hdr_err_o <= 1'b1;
            end else begin
              hdr_fix_o <= ecc_r[24];
              if (ecc_r[5:0] <= `CRXFE_DT_SHORT_MAX) begin
                sync_valid_o <= 1'b1;
                sync_id_o    <= ecc_r[7:0];
                sync_data_o  <= ecc_r[23:8];
                if (ecc_r[5:0] == `CRXFE_DT_FRAME_STA) begin
                  frame_active_o <= 1'b1;
                end else if (ecc_r[5:0] == `CRXFE_DT_FRAME_END) begin
                  frame_active_o <= 1'b0;
                end
              end else begin
                wc_reg  <= ecc_r[23:8];
                crc_reg <= `CRXFE_CRC_INIT;
                ps_reg  <= (ecc_r[23:8] == 16'h0000) ? PS_C0 : PS_PL;
              end
            end
          end
          PS_PL: begin
            crc_reg <= crc_byte(crc_reg, b);
            wc_reg  <= wc_reg - 16'h0001;
            if (wc_reg == 16'h0001) begin
              ps_reg <= PS_C0;
            end
          end
          PS_C0: begin
            cs_lo_reg <= b;
            ps_reg    <= PS_C1;
          end
          default: begin
            crc_err_o <= ({b, cs_lo_reg} != crc_reg);
            ps_reg    <= PS_H0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Payload buffer
  crxfe_skid #(
    .WIDTH (9),
    .AW    (1)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_rdy),
    .in_data_i   ({wc_reg == 16'h0001, b}),
    .out_valid_o (pay_valid_o),
    .out_ready_i (pay_ready_i),
    .out_data_o  ({pay_last_o, pay_data_o})
  );
endmodule // crxfe_top

// ### sim/crxfe_assertions.sv
// Checker of the lane front end port behaviour
`timescale 1ns/100ps
module crxfe_chk (
  // Clock, reset and inputs
  input wire       clk_i,
  input wire       rst_b_i,
  input wire       clk_cont_i,
  input wire [1:0] lane_cfg_i,
  input wire       err_clr_i,
  input wire       lp_cp_i,
  input wire       lp_cn_i,
  input wire [3:0] lp_dp_i,
  input wire [3:0] lp_dn_i,
  input wire       pay_ready_i,
  // Outputs
  input wire       clk_term_en_o,
  input wire [3:0] term_en_o,
  input wire       sync_valid_o,
  input wire [7:0] sync_id_o,
  input wire       frame_active_o,
  input wire       pay_valid_o,
  input wire [7:0] pay_data_o,
  input wire       pay_last_o,
  input wire       hdr_fix_o,
  input wire       hdr_err_o,
  input wire       crc_err_o,
  input wire       crc_err_sts_o,
  input wire       hdr_err_sts_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire [1:0] ln0 = {lp_dp_i[0], lp_dn_i[0]};
  wire [1:0] lnc = {lp_cp_i, lp_cn_i};
  ////////////////////////////////////////
  sequence s_entry;
    (ln0 == 2'b11)[*3] ##1 (ln0 == 2'b01)[*3] ##1 (ln0 == 2'b00)[*3];
  endsequence
  sequence s_stop;
    (ln0 == 2'b11)[*3];
  endsequence
  property p_term_on; s_entry |=> term_en_o[0]; endproperty
  property p_term_off; s_stop |=> !term_en_o[0]; endproperty
  property p_clk_off;
    (!clk_cont_i && lnc == 2'b11)[*3] ##1 !clk_cont_i |-> !clk_term_en_o;
  endproperty
  property p_clk_cont; clk_cont_i |-> clk_term_en_o; endproperty
  property p_lanes; (lane_cfg_i == 2'b00)[*3] |-> term_en_o[3:1] == 3'b000; endproperty
  property p_short; sync_valid_o |-> sync_id_o[5:0] <= 6'h0f; endproperty
  property p_pulse; sync_valid_o |=> !sync_valid_o; endproperty
  property p_frame; sync_valid_o && sync_id_o[5:0] == 6'h00 |=> frame_active_o; endproperty
  property p_hsts; hdr_fix_o || hdr_err_o |=> hdr_err_sts_o; endproperty
  property p_clr; err_clr_i && !crc_err_o |=> !crc_err_sts_o; endproperty
  property p_hold;
    pay_valid_o && !pay_ready_i |=> pay_valid_o && $stable(pay_data_o) && $stable(pay_last_o);
  endproperty
  a_term_on: assert property (p_term_on) else $error("termination not raised");
  a_term_off: assert property (p_term_off) else $error("termination not dropped");
  a_clk_off: assert property (p_clk_off) else $error("clock lane stays on");
  a_clk_cont: assert property (p_clk_cont) else $error("continuous clock off");
  a_lanes: assert property (p_lanes) else $error("unused lane active");
  a_short: assert property (p_short) else $error("sync event with long type");
  a_pulse: assert property (p_pulse) else $error("sync pulse too long");
  a_frame: assert property (p_frame) else $error("frame not opened");
  a_hsts: assert property (p_hsts) else $error("header status not set");
  a_clr: assert property (p_clr) else $error("checksum status not cleared");
  a_hold: assert property (p_hold) else $error("payload changed while stalled");
endmodule // crxfe_chk

// ### sim/crxfe_snr_model.sv
// Sensor model driving the clock lane and four data lanes
`timescale 1ns/100ps
module crxfe_snr_model (
  // Clock lane mode
  input  wire       cont_i,
  // Lane pins
  output reg        hs_clk_o,
  output reg        lp_cp_o,
  output reg        lp_cn_o,
  output reg  [3:0] lp_dp_o,
  output reg  [3:0] lp_dn_o,
  output reg  [3:0] hs_d_o
);
  reg [7:0] q[$];
  reg       run;
  initial begin
    hs_clk_o = 1'b0;
    {lp_cp_o, lp_cn_o} = 2'b11;
    lp_dp_o = 4'hf;
    lp_dn_o = 4'hf;
    hs_d_o = 4'h5;
    run = 1'b0;
  end
  // Link clock only within bursts unless continuous
  always #40 hs_clk_o = (run || cont_i) ? ~hs_clk_o : 1'b0;
  ////////////////////////////////////////
  task dl(input [1:0] s, input int nl);
    integer l;
    for (l = 0; l < nl; l++) {lp_dp_o[l], lp_dn_o[l]} = s;
  endtask
  task grp(input [31:0] w);
    integer i, l;
    for (i = 0; i < 8; i++) begin
      @(negedge hs_clk_o);
      for (l = 0; l < 4; l++) hs_d_o[l] = w[8*l+i];
    end
  endtask
  // Only stop, request and high-speed states, never escape
  task burst(input int nl);
    reg [31:0] w;
    integer    l;
    begin
      {lp_cp_o, lp_cn_o} = cont_i ? 2'b00 : 2'b01;
      #50 {lp_cp_o, lp_cn_o} = 2'b00;
      run = 1'b1;
      #50 dl(2'b01, nl);
      #30 dl(2'b00, nl);
      #50 grp(32'h0);
      grp({4{8'hb8}});
      while (q.size() > 0) begin
        w = 32'h0;
        for (l = 0; l < nl; l++) w[8*l+:8] = q.size() ? q.pop_front() : 8'hff;
        grp(w);
      end
      @(negedge hs_clk_o);
      run = 1'b0;
      hs_d_o = ~hs_d_o;
      #320 dl(2'b11, nl);
      #50 if (!cont_i) {lp_cp_o, lp_cn_o} = 2'b11;
      #100;
    end
  endtask
endmodule // crxfe_snr_model

// ### sim/testbench.sv
// Self-checking bench of the lane front end
`timescale 1ns/100ps
`include "crxfe_regs.vh"
module testbench;
  reg         clk_i = 1'b0;
  reg         rst_b_i = 1'b0;
  reg         clk_cont_i = 1'b0;
  reg  [1:0]  lane_cfg_i = 2'b00;
  reg         err_clr_i = 1'b0;
  reg         pay_ready_i = 1'b1;
  wire        hs_clk_i, lp_cp_i, lp_cn_i, clk_term_en_o, sync_valid_o, frame_active_o;
  wire        pay_valid_o, pay_last_o, hdr_fix_o, hdr_err_o, crc_err_o, ovr_o;
  wire        hdr_err_sts_o, crc_err_sts_o;
  wire [3:0]  lp_dp_i, lp_dn_i, hs_d_i, term_en_o;
  wire [7:0]  sync_id_o, pay_data_o;
  wire [15:0] sync_data_o;
  integer     fails = 0;
  integer     compares = 0;
  integer     n_fix = 0, n_err = 0, n_crc = 0, n_ovr = 0;
  reg  [31:0] seed = 32'hc385fa8f;
  reg  [31:0] exp_s[$], got_s[$], exp_p[$], got_p[$];
  always #5 clk_i = ~clk_i;
  crxfe_top dut_u (.*);
  crxfe_snr_model snr_u (.cont_i(clk_cont_i), .hs_clk_o(hs_clk_i), .lp_cp_o(lp_cp_i),
    .lp_cn_o(lp_cn_i), .lp_dp_o(lp_dp_i), .lp_dn_o(lp_dn_i), .hs_d_o(hs_d_i));
  ////////////////////////////////////////
  function [31:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function [15:0] crc_step(input [15:0] c, input [7:0] b);
    integer i;
    crc_step = c;
    for (i = 0; i < 8; i++) begin
      crc_step = (crc_step >> 1) ^ ((crc_step[0] ^ b[i]) ? `CRXFE_CRC_POLY : 16'h0);
    end
  endfunction
  function [7:0] ecc(input [23:0] h);
    ecc = {2'b00, ^(h & `CRXFE_ECC_M5), ^(h & `CRXFE_ECC_M4), ^(h & `CRXFE_ECC_M3),
           ^(h & `CRXFE_ECC_M2), ^(h & `CRXFE_ECC_M1), ^(h & `CRXFE_ECC_M0)};
  endfunction
  always @(negedge clk_i) pay_ready_i <= (rnd() & 3) != 0;
  always @(posedge clk_i) begin
    if (sync_valid_o) got_s.push_back({sync_data_o, sync_id_o});
    if (pay_valid_o && pay_ready_i) got_p.push_back({pay_last_o, pay_data_o});
    n_fix = n_fix + hdr_fix_o;
    n_err = n_err + hdr_err_o;
    n_crc = n_crc + crc_err_o;
    n_ovr = n_ovr + ovr_o;
  end
  ////////////////////////////////////////
  task cmp(input string what, input [31:0] e, input [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task pkt(input [7:0] id, input [15:0] wc, input [23:0] flip, input bad);
    reg [23:0] h;
    reg [15:0] c;
    reg [7:0]  b;
    integer    i;
    begin
      h = {wc, id};
      c = `CRXFE_CRC_INIT;
      for (i = 0; i < 3; i++) snr_u.q.push_back(h[8*i+:8] ^ flip[8*i+:8]);
      snr_u.q.push_back(ecc(h));
      if (id[5:0] > `CRXFE_DT_SHORT_MAX) begin
        for (i = 0; i < wc; i++) begin
          b = rnd();
          c = crc_step(c, b);
          snr_u.q.push_back(b);
          exp_p.push_back({i == wc - 1, b});
        end
        c = c ^ {15'h0, bad};
        snr_u.q.push_back(c[7:0]);
        snr_u.q.push_back(c[15:8]);
      end else if ($countones(flip) < 2) begin
        exp_s.push_back({wc, id});
      end
    end
  endtask
  task done(input string name, input int nl, input int ef, input int ee, input int ec);
    integer f0;
    begin
      f0 = fails;
      lane_cfg_i = (nl == 4) ? 2'b10 : (nl == 2) ? 2'b01 : 2'b00;
      snr_u.burst(nl);
      repeat (30) @(negedge clk_i);
      cmp("sync count", exp_s.size(), got_s.size());
      while (exp_s.size() && got_s.size()) begin
        cmp("sync event", exp_s.pop_front(), got_s.pop_front());
      end
      cmp("byte count", exp_p.size(), got_p.size());
      while (exp_p.size() && got_p.size()) begin
        cmp("payload", exp_p.pop_front(), got_p.pop_front());
      end
      cmp("overrun", 0, n_ovr);
      cmp("header fix", ef, n_fix);
      cmp("header drop", ee, n_err);
      cmp("checksum error", ec, n_crc);
      cmp("termination", {clk_cont_i, 4'h0}, {clk_term_en_o, term_en_o});
      exp_s.delete();
      got_s.delete();
      exp_p.delete();
      got_p.delete();
      n_fix = 0;
      n_err = 0;
      n_crc = 0;
      n_ovr = 0;
      $display("Test %s ended with %0d mismatches", name, fails - f0);
    end
  endtask
  task end_sim;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    pkt(8'h00, rnd(), 24'h0, 1'b0);
    pkt(8'h2a, 16'h0005, 24'h0, 1'b0);
    done("frame start one lane", 1, 0, 0, 0);
    cmp("frame open", 1, frame_active_o);
    pkt(8'h02, rnd(), 24'h0, 1'b0);
    pkt(8'h2b, 16'h0001 + rnd() % 40, 24'h0, 1'b0);
    done("two lanes", 2, 0, 0, 0);
    pkt(8'h2c, 16'h0010, 24'h0, 1'b1);
    pkt(8'h2a, 16'h0003, 24'h1 << (rnd() % 24), 1'b0);
    done("four lanes with faults", 4, 1, 0, 1);
    cmp("sticky status", 2'b11, {hdr_err_sts_o, crc_err_sts_o});
    err_clr_i = 1'b1;
    @(negedge clk_i);
    err_clr_i = 1'b0;
    @(negedge clk_i);
    cmp("cleared status", 2'b00, {hdr_err_sts_o, crc_err_sts_o});
    pkt(8'h03, rnd(), 24'h000101, 1'b0);
    done("double header error", 1, 0, 1, 0);
    clk_cont_i = 1'b1;
    pkt(8'h01, rnd(), 24'h0, 1'b0);
    done("continuous clock", 2, 0, 0, 0);
    cmp("frame closed", 0, frame_active_o);
    end_sim;
  end
  initial begin
    #500000;
    fails = fails + 1;
    $display("Error watchdog expired");
    end_sim;
  end
endmodule // testbench
bind crxfe_top crxfe_chk chk_u (.*);
